// *** src/eesp_host.sv ***
// Programmer end: APB-controlled frame generator and strobe timer
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
module eesp_host
    import eesp_pkg::*;
#(
    parameter int SCLK_HALF   = SCLK_HALF_DEF,
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
)
(
    input  wire logic        clock,
    input  wire logic        rst,
    eesp_if.host             link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    localparam int PW = $clog2(PROG_CYCLES + 1);
    localparam int DW = $clog2(SCLK_HALF + 1);

    generate
        if (SCLK_HALF < SCLK_HALF_MIN || PROG_CYCLES < 1)
        begin : g_bad
            $error("eesp_host: SCLK_HALF or PROG_CYCLES out of range");
        end
    endgenerate

    typedef enum logic [5:0] {
        H_IDLE  = 6'b000001,
        H_LEAD  = 6'b000010,
        H_SHIFT = 6'b000100,
        H_TAIL  = 6'b001000,
        H_PROG  = 6'b010000,
        H_GAP   = 6'b100000
    } eesp_state_e;

    eesp_state_e           state_r;
    logic [DW-1:0]         div_r;
    logic [CNT_W-1:0]      bit_r;
    logic [FRAME_BITS-1:0] tx_r;
    logic [DATA_W-1:0]     rx_r;
    logic [PW-1:0]         prog_r;
    logic                  test_r;
    logic                  sclk_r;
    logic                  en_r;
    logic                  sdi_r;
    logic                  vpp_r;
    logic                  done_r;
    logic [31:0]           prdata_r;
    logic                  pready_r;
    logic                  pslverr_r;
    logic                  sdo_s;

    eesp_sync #(.WIDTH(1)) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (link.serial_out),
        .sync_out (sdo_s)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire        acc      = psel & penable & pready_r;
    wire        wr       = acc & pwrite;
    wire        hit      = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_STATUS) ||
                           (paddr == REG_RDATA);
    wire        busy     = (state_r != H_IDLE);
    // Commands while busy or outside test mode are dropped
    wire        start    = wr & (paddr == REG_CMD) & ~busy & test_r;
    wire        done_clr = wr & (paddr == REG_STATUS) & pwdata[STAT_DONE_BIT];
    wire [FRAME_BITS-1:0] frame = {pwdata[CMD_DATA_LSB+DATA_W-1:CMD_DATA_LSB] & {DATA_W{~pwdata[CMD_READ_BIT]}},
                                   FILL_ZERO, pwdata[CMD_READ_BIT:0]};
    wire [31:0] rd_mux   = (paddr == REG_CTRL)   ? {31'h0, test_r} :
                           (paddr == REG_STATUS) ? {30'h0, done_r, busy} :
                           (paddr == REG_RDATA)  ? {24'h0, rx_r} :
                                                   32'h0;
    wire        tick     = (div_r == DW'(SCLK_HALF - 1));
    wire        is_read  = (tx_r[OP_POS] == OP_READ);

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
            test_r    <= 1'b0;
        end
        else
        begin
            pready_r  <= psel & penable & ~pready_r;
            prdata_r  <= rd_mux;
            pslverr_r <= psel & penable & ~pready_r & ~hit;
            if (wr & (paddr == REG_CTRL))
                test_r <= pwdata[CTRL_TEST_BIT];
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_r <= H_IDLE;
            div_r   <= '0;
            bit_r   <= '0;
            tx_r    <= '0;
            rx_r    <= '0;
            prog_r  <= '0;
            sclk_r  <= 1'b0;
            en_r    <= 1'b0;
            sdi_r   <= 1'b0;
            vpp_r   <= 1'b0;
            done_r  <= 1'b0;
        end
        else
        begin
            div_r <= (tick | ~busy) ? '0 : div_r + DW'(1);
            unique case (state_r)
                H_IDLE:
                begin
                    if (start)
                    begin
                        tx_r    <= frame;
                        bit_r   <= '0;
                        en_r    <= 1'b1;
                        sdi_r   <= frame[0];
                        state_r <= H_LEAD;
                    end
                end
                H_LEAD:
                begin
                    if (tick)
                        state_r <= H_SHIFT;
                end
                H_SHIFT:
                begin
                    if (tick & ~sclk_r)
                    begin
                        sclk_r <= 1'b1;
                        if (bit_r >= DATA_START)
                            rx_r[bit_r[2:0]] <= sdo_s;
                        bit_r <= bit_r + 5'h01;
                    end
                    else if (tick)
                    begin
                        sclk_r <= 1'b0;
                        if (bit_r == CNT_FULL)
                        begin
                            en_r    <= 1'b0;
                            sdi_r   <= 1'b0;
                            state_r <= H_TAIL;
                        end
                        else
                            sdi_r <= tx_r[bit_r[3:0]];
                    end
                end
                H_TAIL:
                begin
                    if (tick & is_read)
                        state_r <= H_GAP;
                    else if (tick)
                    begin
                        vpp_r   <= 1'b1;
                        prog_r  <= '0;
                        state_r <= H_PROG;
                    end
                end
                H_PROG:
                begin
                    prog_r <= prog_r + PW'(1);
                    if (prog_r == PW'(PROG_CYCLES - 1))
                    begin
                        vpp_r   <= 1'b0;
                        state_r <= H_GAP;
                    end
                end
                H_GAP:
                begin
                    if (tick)
                        state_r <= H_IDLE;
                end
            endcase
            if (state_r == H_GAP && tick)
                done_r <= 1'b1;
            else if (done_clr)
                done_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.test_strap            = test_r;
    assign link.shift_clock           = sclk_r;
    assign link.transfer_frame_enable = en_r;
    assign link.serial_in             = sdi_r;
    assign link.prog_strobe           = vpp_r;
    assign prdata                     = prdata_r;
    assign pready                     = pready_r;
    assign pslverr                    = pslverr_r;
endmodule

// *** src/eesp_pkg.sv ***
// Shared constants for the serial configuration port and its programmer
package eesp_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int          FRAME_BITS    = 16;
    localparam int          CNT_W         = 5;
    localparam logic [4:0]  CNT_FULL      = 5'h10;
    localparam logic [4:0]  CNT_SAT       = 5'h1F;
    localparam logic [4:0]  ECHO_FIRST    = 5'h07;
    localparam logic [4:0]  ECHO_LAST     = 5'h0E;
    localparam logic [4:0]  DATA_START    = 5'h08;
    localparam int          ADDR_LSB_POS  = 0;
    localparam int          ADDR_MSB_POS  = 1;
    localparam int          OP_POS        = 2;
    localparam int          FILL_LSB_POS  = 3;
    localparam int          FILL_MSB_POS  = 7;
    localparam int          DATA_LSB_POS  = 8;
    localparam int          DATA_MSB_POS  = 15;
    localparam int          DATA_W        = 8;
    localparam logic        OP_READ       = 1'b1;
    localparam logic        OP_WRITE      = 1'b0;
    localparam logic [4:0]  FILL_ZERO     = 5'h00;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    localparam int          NUM_REGS             = 2;
    localparam logic [1:0]  LOOP_FILTER_CONFIG   = 2'h0;
    localparam logic [1:0]  POLE_AND_SPEED_CONFIG = 2'h1;
    localparam int          ZERO_MSB  = 7;
    localparam int          ZERO_LSB  = 5;
    localparam int          COAST_BIT = 4;
    localparam int          SYNC_BIT  = 3;
    localparam int          GAIN_MSB  = 2;
    localparam int          GAIN_LSB  = 0;
    localparam int          POLE_MSB  = 7;
    localparam int          POLE_LSB  = 2;
    localparam int          FSEL_MSB  = 1;
    localparam int          FSEL_LSB  = 0;
    localparam logic [7:0]  LOOP_FILTER_DEFAULT = 8'h80;
    localparam logic [7:0]  POLE_SPEED_DEFAULT  = 8'h70;

    // ------------------------------------------------------------
    // Programmer register map and timing
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_CMD      = 8'h04;
    localparam logic [7:0]  REG_STATUS   = 8'h08;
    localparam logic [7:0]  REG_RDATA    = 8'h0C;
    localparam int          CTRL_TEST_BIT = 0;
    localparam int          CMD_READ_BIT  = 2;
    localparam int          CMD_DATA_LSB  = 8;
    localparam int          STAT_BUSY_BIT = 0;
    localparam int          STAT_DONE_BIT = 1;
    localparam int          SYNC_STAGES   = 3;
    localparam int          CLK_FREQ_MHZ  = 25;
    localparam int          PROG_TIME_US  = 5000;
    localparam int          PROG_CYCLES_DEF = PROG_TIME_US * CLK_FREQ_MHZ;
    localparam int          SCLK_HALF_DEF = 8;
    localparam int          SCLK_HALF_MIN = 5;

endpackage

// *** src/eesp_if.sv ***
// Serial configuration link between programmer and device
`timescale 1ns/100ps
interface eesp_if;
    logic test_strap;
    logic shift_clock;
    logic transfer_frame_enable;
    logic serial_in;
    logic prog_strobe;
    logic serial_out;

    modport device (
        input  test_strap,
        input  shift_clock,
        input  transfer_frame_enable,
        input  serial_in,
        input  prog_strobe,
        output serial_out
    );

    modport host (
        output test_strap,
        output shift_clock,
        output transfer_frame_enable,
        output serial_in,
        output prog_strobe,
        input  serial_out
    );
endinterface

// *** src/eesp_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module eesp_sync
    import eesp_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;

    // Stage 1 feeds stage 2 only; the filter looks at stages 2 and 3
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            assign out_nxt[i] = (stage2_r[i] == stage3_r[i]) ? stage3_r[i] : out_r[i];
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
            out_r    <= '0;
        end
        else
        begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            out_r    <= out_nxt;
        end
    end

    assign sync_out = out_r;
endmodule

// *** src/eesp_device.sv ***
// Device end: serial configuration port with two nonvolatile registers
`timescale 1ns/100ps
module eesp_device
    import eesp_pkg::*;
#(
    parameter logic [7:0] LOOP_RESET = LOOP_FILTER_DEFAULT,
    parameter logic [7:0] POLE_RESET = POLE_SPEED_DEFAULT
)
(
    input  wire logic  clock,
    input  wire logic  rst,
    eesp_if.device     link,
    input  wire logic  normal_speed_out,
    output logic       normal_freq_sel,
    output logic       normal_start_stop,
    output logic       normal_direction,
    output logic       test_mode,
    output logic [2:0] filter_zero_coeff,
    output logic       coast_enable,
    output logic       sync_rect_enable,
    output logic [2:0] integ_gain_sel,
    output logic [5:0] filter_pole_coeff,
    output logic [1:0] speed_feedback_sel,
    output logic       commit_pulse,
    output logic       frame_discarded
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [4:0] pins_s;
    logic       test_s;
    logic       sclk_s;
    logic       en_s;
    logic       sdi_s;
    logic       vpp_s;

    eesp_sync #(.WIDTH(5)) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({link.test_strap, link.shift_clock, link.transfer_frame_enable,
                    link.serial_in, link.prog_strobe}),
        .sync_out (pins_s)
    );

    assign test_s = pins_s[4];
    assign sclk_s = pins_s[3];
    assign en_s   = pins_s[2];
    assign sdi_s  = pins_s[1];
    assign vpp_s  = pins_s[0];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [CNT_W-1:0]      cnt_r;
    logic [CNT_W-1:0]      cnt_nxt;
    logic [FRAME_BITS-1:0] frame_sr_r;
    logic [FRAME_BITS-1:0] inreg_r;
    logic                  inreg_valid_r;
    logic [DATA_W-1:0]     nvm_r [0:NUM_REGS-1];
    logic                  sclk_q_r;
    logic                  en_q_r;
    logic                  vpp_q_r;
    logic                  pin14_r;
    logic                  pin14_nxt;
    logic [2:0]            normal_r;
    logic                  commit_r;
    logic                  discard_r;

    function automatic logic addr_ok(input logic [1:0] a);
        addr_ok = (a == LOOP_FILTER_CONFIG) || (a == POLE_AND_SPEED_CONFIG);
    endfunction

    // ------------------------------------------------------------
    // Edge and frame decode
    // ------------------------------------------------------------
    wire                     sclk_rise   = sclk_s & ~sclk_q_r;
    wire                     en_rise     = en_s & ~en_q_r;
    wire                     en_fall     = ~en_s & en_q_r;
    wire                     vpp_rise    = vpp_s & ~vpp_q_r;
    wire                     shift_now   = test_s & en_s & ~en_rise & sclk_rise;
    wire                     store_bit   = shift_now & (cnt_r < CNT_FULL);
    wire                     frame_good  = test_s & en_fall & (cnt_r == CNT_FULL);
    wire                     frame_bad   = test_s & en_fall & (cnt_r != CNT_FULL);
    wire [1:0]               rx_addr     = frame_sr_r[ADDR_MSB_POS:ADDR_LSB_POS];
    wire                     rx_read     = (frame_sr_r[OP_POS] == OP_READ);
    wire [DATA_W-1:0]        rd_byte     = addr_ok(rx_addr) ? nvm_r[rx_addr[0]] : '0;
    wire [CNT_W-1:0]         echo_idx    = cnt_r - ECHO_FIRST;
    wire                     echo_window = (cnt_r >= ECHO_FIRST) && (cnt_r <= ECHO_LAST);
    wire                     echo_bit    = rx_read & rd_byte[echo_idx[2:0]];
    wire [1:0]               wr_addr     = inreg_r[ADDR_MSB_POS:ADDR_LSB_POS];
    wire [DATA_W-1:0]        wr_data     = inreg_r[DATA_MSB_POS:DATA_LSB_POS];
    wire                     wr_op       = (inreg_r[OP_POS] == OP_WRITE);
    // Strobe accepted only outside a frame and once per latched frame
    wire                     commit      = test_s & ~en_s & vpp_rise & inreg_valid_r & wr_op
                                           & addr_ok(wr_addr);

    // Bit counter restarts at each frame and saturates on overlong frames
    assign cnt_nxt = (~test_s | en_rise)                ? '0 :
                     (shift_now && cnt_r != CNT_SAT)    ? cnt_r + 5'h01 :
                                                          cnt_r;

    // Outside test mode pin 14 carries the normal speed output
    assign pin14_nxt = ~test_s                  ? normal_speed_out :
                       ~en_s                    ? 1'b0 :
                       (shift_now & echo_window) ? echo_bit :
                                                  pin14_r;

    // ------------------------------------------------------------
    // Serial shifting
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sclk_q_r   <= 1'b0;
            en_q_r     <= 1'b0;
            vpp_q_r    <= 1'b0;
            cnt_r      <= '0;
            frame_sr_r <= '0;
            pin14_r    <= 1'b0;
        end
        else
        begin
            sclk_q_r <= sclk_s;
            en_q_r   <= en_s;
            vpp_q_r  <= vpp_s;
            cnt_r    <= cnt_nxt;
            pin14_r  <= pin14_nxt;
            if (test_s & en_rise)
                frame_sr_r <= '0;
            else if (store_bit)
                frame_sr_r[cnt_r[3:0]] <= sdi_s;
        end
    end

    // ------------------------------------------------------------
    // Input register and nonvolatile store
    // ------------------------------------------------------------
    // A new frame outranks a strobe in the same cycle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            inreg_r       <= '0;
            inreg_valid_r <= 1'b0;
        end
        else if (frame_good)
        begin
            inreg_r       <= frame_sr_r;
            inreg_valid_r <= 1'b1;
        end
        else if (vpp_rise | ~test_s)
            inreg_valid_r <= 1'b0;
    end

    // Reset stands in for the stored contents, which real cells keep
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            nvm_r[LOOP_FILTER_CONFIG[0]]    <= LOOP_RESET;
            nvm_r[POLE_AND_SPEED_CONFIG[0]] <= POLE_RESET;
        end
        else if (commit)
            nvm_r[wr_addr[0]] <= wr_data;
    end

    // ------------------------------------------------------------
    // Normal pin functions and status
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            normal_r  <= '0;
            commit_r  <= 1'b0;
            discard_r <= 1'b0;
        end
        else
        begin
            // Last normal levels are held while pins serve the serial port
            if (~test_s)
                normal_r <= {sclk_s, en_s, sdi_s};
            commit_r  <= commit;
            discard_r <= frame_bad;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.serial_out      = pin14_r;
    assign normal_freq_sel      = normal_r[2];
    assign normal_start_stop    = normal_r[1];
    assign normal_direction     = normal_r[0];
    assign test_mode            = test_s;
    assign filter_zero_coeff    = nvm_r[LOOP_FILTER_CONFIG[0]][ZERO_MSB:ZERO_LSB];
    assign coast_enable         = nvm_r[LOOP_FILTER_CONFIG[0]][COAST_BIT];
    assign sync_rect_enable     = nvm_r[LOOP_FILTER_CONFIG[0]][SYNC_BIT];
    assign integ_gain_sel       = nvm_r[LOOP_FILTER_CONFIG[0]][GAIN_MSB:GAIN_LSB];
    assign filter_pole_coeff    = nvm_r[POLE_AND_SPEED_CONFIG[0]][POLE_MSB:POLE_LSB];
    assign speed_feedback_sel   = nvm_r[POLE_AND_SPEED_CONFIG[0]][FSEL_MSB:FSEL_LSB];
    assign commit_pulse         = commit_r;
    assign frame_discarded      = discard_r;
endmodule

// *** verification/eesp_link_properties.sv ***
// Link checker for the serial configuration port
`timescale 1ns/100ps
module eesp_link_properties #(parameter int PROG_CYCLES = 20)
(
    input logic clock,
    input logic rst,
    input logic test_strap,
    input logic shift_clock,
    input logic transfer_frame_enable,
    input logic serial_in,
    input logic prog_strobe,
    input logic serial_out
);
    logic       sclk_q;
    logic [4:0] cnt;
    int         scnt;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Counters live outside the properties so long spans stay cheap
    always_ff @(posedge clock)
    begin
        sclk_q <= shift_clock;
        scnt   <= prog_strobe ? scnt + 1 : 0;
        cnt    <= (rst || !transfer_frame_enable) ? 5'h00 : cnt + 5'(shift_clock && !sclk_q);
    end
    a_strap_held: assert property (transfer_frame_enable |-> test_strap) else $error("frame outside test mode");
    a_first_rise_late: assert property ($rose(transfer_frame_enable) |-> !shift_clock [*5])
        else $error("clock rose too soon");
    a_clock_in_frame: assert property ($rose(shift_clock) |-> transfer_frame_enable) else $error("stray clock");
    a_filler_zero: assert property ($rose(shift_clock) && cnt >= 5'h03 && cnt <= 5'h07 |-> !serial_in)
        else $error("filler bit set");
    a_sixteen_rises: assert property ($fell(transfer_frame_enable) |-> cnt == 5'h10) else $error("bad bit count");
    a_strobe_after_frame: assert property ($rose(prog_strobe) |-> !transfer_frame_enable)
        else $error("strobe in frame");
    a_strobe_width: assert property ($fell(prog_strobe) |-> scnt == PROG_CYCLES) else $error("strobe width");
    a_echo_idle_low: assert property ((test_strap && !transfer_frame_enable) [*8] |-> !serial_out)
        else $error("output busy when idle");
endmodule

// *** verification/eesp_serial_config_port_bench.sv ***
// Self-checking bench joining programmer and device ends
`timescale 1ns/100ps
module eesp_serial_config_port_bench;
    import eesp_pkg::*;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, nso, er, ce, sr, tm, cp, fd, nfs, nss, ndr;
    logic [7:0]  paddr, wd, ex [0:3];
    logic [31:0] pwdata, prdata, rd, s;
    logic [2:0]  zc, gs;
    logic [5:0]  pc;
    logic [1:0]  fs, wa;
    int          bad_count, num_checks, nwr, ncom, ndis;
    wire  [7:0]  r0 = {zc, ce, sr, gs};
    wire  [7:0]  r1 = {pc, fs};
    eesp_if link();
    eesp_device i_eesp_device (.clock, .rst, .link(link.device), .normal_speed_out(nso),
        .normal_freq_sel(nfs), .normal_start_stop(nss), .normal_direction(ndr), .test_mode(tm),
        .filter_zero_coeff(zc), .coast_enable(ce), .sync_rect_enable(sr), .integ_gain_sel(gs),
        .filter_pole_coeff(pc), .speed_feedback_sel(fs), .commit_pulse(cp), .frame_discarded(fd));
    eesp_host #(.PROG_CYCLES(20)) i_eesp_host (.clock, .rst, .link(link.host), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);
    eesp_link_properties #(.PROG_CYCLES(20)) i_eesp_link_properties (.clock, .rst, .test_strap(link.test_strap),
        .shift_clock(link.shift_clock), .transfer_frame_enable(link.transfer_frame_enable),
        .serial_in(link.serial_in), .prog_strobe(link.prog_strobe), .serial_out(link.serial_out));
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Pulses are counted so that a lost or doubled commit shows at the end
    always @(posedge clock)
    begin
        if (!rst)
        begin
            ncom <= ncom + cp;
            ndis <= ndis + fd;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Master waits on pready with a bound rather than assuming the one-cycle wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50)
        begin
            chk(0, 1);
            end_of_test();
        end
    endtask
    task automatic cmd(input logic [1:0] a, input logic op, input logic [7:0] d);
        int n;
        apb(1'b1, REG_CMD, {16'h0000, d, 5'h00, op, a});
        n = 0;
        do
        begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end
        while (rd[1] !== 1'b1 && n < 200);
        if (n >= 200)
        begin
            chk(0, 1);
            end_of_test();
        end
        apb(1'b1, REG_STATUS, 32'h2);
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, nso} = '0;
        bad_count = 0; num_checks = 0; s = 32'h6AAF59E0; rst = 1'b1;
        nwr = 0; ncom = 0; ndis = 0;
        ex = '{LOOP_FILTER_DEFAULT, POLE_SPEED_DEFAULT, 8'h00, 8'h00};
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        nso <= 1'b1;
        apb(1'b1, REG_CMD, 32'h0000_5500);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[0], 1'b0);
        chk(link.serial_out, 1'b1);
        chk({r1, r0}, {ex[1], ex[0]});
        apb(1'b0, 8'h40, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (8) @(posedge clock);
        chk(tm, 1'b1);
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h1);
        for (int i = 0; i < 12; i++)
        begin
            s = lfsr(s);
            nso <= s[20];
            // Corner values first on real registers, then any address, unmapped ones included
            wa = (i < 2) ? {1'b0, s[0]} : s[1:0];
            wd = (i == 0) ? 8'h01 : (i == 1) ? 8'hFE : s[15:8];
            if (!wa[1])
            begin
                ex[wa[0]] = wd;
                nwr++;
            end
            cmd(wa, OP_WRITE, wd);
            chk({r1, r0}, {ex[1], ex[0]});
            cmd(s[3:2], OP_READ, 8'h00);
            apb(1'b0, REG_RDATA, 32'h0);
            chk(rd[7:0], ex[s[3:2]]);
        end
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (8) @(posedge clock);
        chk(tm, 1'b0);
        chk(link.serial_out, nso);
        chk({nfs, nss, ndr}, 3'h0);
        chk(ncom, nwr);
        chk(ndis, 0);
        end_of_test();
    end
endmodule
